/* File: hdl/smb_pkg.sv */
package smb_pkg;

  // ---------------------------------------------------------------------------
  // Word and buffer sizes.
  // ---------------------------------------------------------------------------
  localparam int WORD_W       = 8;
  localparam int FIFO_DEPTH   = 4;
  localparam int HALF_PERIODS = 2 * WORD_W;

  // ---------------------------------------------------------------------------
  // Buffer interrupt select encodings.
  // ---------------------------------------------------------------------------
  localparam logic [2:0] ISEL_RX_EMPTY    = 3'h0;
  localparam logic [2:0] ISEL_RX_NONEMPTY = 3'h1;
  localparam logic [2:0] ISEL_RX_3QUARTER = 3'h2;
  localparam logic [2:0] ISEL_RX_FULL     = 3'h3;
  localparam logic [2:0] ISEL_SR_LOADED   = 3'h4;
  localparam logic [2:0] ISEL_XFER_DONE   = 3'h5;
  localparam logic [2:0] ISEL_TX_EMPTY    = 3'h6;
  localparam logic [2:0] ISEL_TX_NOTFULL  = 3'h7;

  // ---------------------------------------------------------------------------
  // Reset values.
  // ---------------------------------------------------------------------------
  localparam logic RST_TOGGLE = 1'b0;
  localparam logic RST_FLAG   = 1'b0;

  // ---------------------------------------------------------------------------
  // Status word layout, bit 7 down to bit 0.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic       shift_register_empty_flag;
    logic [1:0] reserved;
    logic [2:0] buffer_interrupt_select;
    logic       tx_full;
    logic       receive_buffer_full_flag;
  } smb_status_type;

  // ---------------------------------------------------------------------------
  // Link configuration carried into the link clock domain.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic clock_edge_select;
    logic clock_idle_level;
  } smb_link_cfg_type;

endpackage

/* File: hdl/smb_shift_engine.sv */
module smb_shift_engine #(
  parameter int WORD_W = smb_pkg::WORD_W
) (
  input  wire logic                     link_clock,
  input  wire logic                     rst,
  input  wire logic                     start_toggle,
  input  wire logic [WORD_W-1:0]        tx_word,
  input  wire smb_pkg::smb_link_cfg_type cfg,
  input  wire logic                     miso,
  output logic                          done_toggle,
  output logic [WORD_W-1:0]             rx_word,
  output logic                          sck,
  output logic                          mosi
);

  typedef enum logic {SMB_IDLE, SMB_SHIFT} smb_state_type;

  // ---------------------------------------------------------------------------
  // Crossing of the start toggle and the configuration.
  // ---------------------------------------------------------------------------
  logic                       req_s1_q;
  logic                       req_s2_q;
  smb_pkg::smb_link_cfg_type  cfg_s1_q;
  smb_pkg::smb_link_cfg_type  cfg_s2_q;

  always_ff @(posedge link_clock or posedge rst) begin
    if (rst) begin
      req_s1_q <= smb_pkg::RST_TOGGLE;
      req_s2_q <= smb_pkg::RST_TOGGLE;
      cfg_s1_q <= '0;
      cfg_s2_q <= '0;
    end else begin
      req_s1_q <= start_toggle;
      req_s2_q <= req_s1_q;
      cfg_s1_q <= cfg;
      cfg_s2_q <= cfg_s1_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Shifter.
  // ---------------------------------------------------------------------------
  smb_state_type      state_q;
  logic [4:0]         half_q;
  logic [WORD_W-1:0]  tx_q;
  logic [WORD_W-1:0]  rx_q;
  logic               sck_q;
  logic               mosi_q;
  logic               done_q;

  wire logic cke      = cfg_s2_q.clock_edge_select;
  wire logic idle_lvl = cfg_s2_q.clock_idle_level;
  wire logic start    = (state_q == SMB_IDLE) && (req_s2_q != done_q);
  wire logic lead     = (sck_q == idle_lvl);
  wire logic sample   = (lead == cke);
  wire logic last     = (half_q == 5'(smb_pkg::HALF_PERIODS - 1));
  wire logic out_bit  = cke ? tx_q[WORD_W-2] : tx_q[WORD_W-1];

  always_ff @(posedge link_clock or posedge rst) begin
    if (rst) begin
      state_q <= SMB_IDLE;
      half_q  <= '0;
      tx_q    <= '0;
      rx_q    <= '0;
      sck_q   <= 1'b0;
      mosi_q  <= 1'b0;
      done_q  <= smb_pkg::RST_TOGGLE;
    end else begin
      unique case (state_q)
        SMB_IDLE: begin
          sck_q <= idle_lvl;
          if (start) begin
            state_q <= SMB_SHIFT;
            half_q  <= '0;
            tx_q    <= tx_word;
            if (cke) begin
              mosi_q <= tx_word[WORD_W-1];
            end
          end
        end
        SMB_SHIFT: begin
          sck_q  <= ~sck_q;
          half_q <= half_q + 5'h01;
          if (sample) begin
            rx_q <= {rx_q[WORD_W-2:0], miso};
          end else begin
            mosi_q <= out_bit;
            tx_q   <= {tx_q[WORD_W-2:0], 1'b0};
          end
          if (last) begin
            state_q <= SMB_IDLE;
            done_q  <= ~done_q;
          end
        end
      endcase
    end
  end

  assign done_toggle = done_q;
  assign rx_word     = rx_q;
  assign sck         = sck_q;
  assign mosi        = mosi_q;

  idle_clock_a: assert property (@(posedge link_clock) disable iff (rst)
    (state_q == SMB_IDLE) && $past(state_q == SMB_IDLE) |->
    sck_q == $past(idle_lvl))
    else $error("serial clock left idle level between transfers");

  edge_data_a: assert property (@(posedge link_clock) disable iff (rst)
    (state_q == SMB_SHIFT) && cke && (sck_q != idle_lvl) |=> $stable(rx_q))
    else $error("sample taken on wrong edge with edge select set");

  frame_len_a: assert property (@(posedge link_clock) disable iff (rst)
    start |=> (state_q == SMB_SHIFT) [*8] ##1 (state_q == SMB_SHIFT) [*8]
    ##1 (state_q == SMB_IDLE))
    else $error("frame did not last sixteen half periods");

endmodule

/* File: hdl/smb_spi_master.sv */
// Summary of operation
// - Enable bit high selects FIFO buffering; low selects single buffers.
// - Three-bit select picks one of eight buffer interrupt conditions.
// - Select 101 raises interrupt only after last bit leaves shifter.
// - Select 110 raises interrupt when transmit FIFO becomes empty.
// - Status bit 7 shows shift register empty for polling.
// - Receive-full, and in standard mode the interrupt, set on the completing clock edge, never early.
// - Edge select high changes output data on active-to-idle clock edge.
module smb_spi_master #(
  parameter int WORD_W = smb_pkg::WORD_W,
  parameter int DEPTH  = smb_pkg::FIFO_DEPTH
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  link_clock,
  input  wire logic                  enhanced_buffer_enable,
  input  wire logic [2:0]            buffer_interrupt_select,
  input  wire logic                  clock_edge_select,
  input  wire logic                  clock_idle_level,
  input  wire logic [WORD_W-1:0]     tx_data,
  input  wire logic                  tx_write,
  input  wire logic                  rx_read,
  input  wire logic                  interrupt_clear,
  output logic [WORD_W-1:0]          rx_data,
  output logic                       tx_full,
  output logic                       receive_buffer_full_flag,
  output logic                       shift_register_empty_flag,
  output logic                       serial_interrupt_flag,
  output smb_pkg::smb_status_type    serial_status_register,
  output logic                       sck,
  output logic                       mosi,
  input  wire logic                  miso
);

  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ---------------------------------------------------------------------------
  // Buffer limits.
  // ---------------------------------------------------------------------------
  wire logic [CNT_W-1:0] limit = enhanced_buffer_enable ?
                                 CNT_W'(DEPTH) : CNT_W'(1);

  logic [WORD_W-1:0] tx_mem [DEPTH];
  logic [WORD_W-1:0] rx_mem [DEPTH];
  logic [PTR_W-1:0]  tx_wp_q;
  logic [PTR_W-1:0]  tx_rp_q;
  logic [PTR_W-1:0]  rx_wp_q;
  logic [PTR_W-1:0]  rx_rp_q;
  logic [CNT_W-1:0]  tx_cnt_q;
  logic [CNT_W-1:0]  rx_cnt_q;

  // ---------------------------------------------------------------------------
  // Handshake with the link clock domain.
  // ---------------------------------------------------------------------------
  logic               req_q;
  logic               ack_s1_q;
  logic               ack_s2_q;
  logic               ack_seen_q;
  logic [WORD_W-1:0]  hold_q;
  logic               link_done;
  logic [WORD_W-1:0]  link_rx;

  wire logic busy     = (req_q != ack_seen_q);
  wire logic done_evt = (ack_s2_q != ack_seen_q);
  wire logic tx_empty = (tx_cnt_q == '0);
  wire logic tx_full_w = (tx_cnt_q >= limit);
  wire logic rx_full_w = (rx_cnt_q >= limit);
  wire logic start    = !busy && !tx_empty;
  wire logic push_tx  = tx_write && !tx_full_w;
  wire logic pop_rx   = rx_read && (rx_cnt_q != '0);
  wire logic push_rx  = done_evt && !rx_full_w;

  function automatic logic [PTR_W-1:0] inc(input logic [PTR_W-1:0] p);
    inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_s1_q   <= smb_pkg::RST_TOGGLE;
      ack_s2_q   <= smb_pkg::RST_TOGGLE;
      ack_seen_q <= smb_pkg::RST_TOGGLE;
      req_q      <= smb_pkg::RST_TOGGLE;
      hold_q     <= '0;
    end else begin
      ack_s1_q <= link_done;
      ack_s2_q <= ack_s1_q;
      if (done_evt) begin
        ack_seen_q <= ack_s2_q;
      end
      if (start) begin
        hold_q <= tx_mem[tx_rp_q];
        req_q  <= ~req_q;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Transmit and receive buffers.
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (push_tx) begin
      tx_mem[tx_wp_q] <= tx_data;
    end
    if (push_rx) begin
      rx_mem[rx_wp_q] <= link_rx;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_wp_q  <= '0;
      tx_rp_q  <= '0;
      rx_wp_q  <= '0;
      rx_rp_q  <= '0;
      tx_cnt_q <= '0;
      rx_cnt_q <= '0;
    end else begin
      if (push_tx) begin
        tx_wp_q <= enhanced_buffer_enable ? inc(tx_wp_q) : '0;
      end
      if (start) begin
        tx_rp_q <= enhanced_buffer_enable ? inc(tx_rp_q) : '0;
      end
      if (push_rx) begin
        rx_wp_q <= enhanced_buffer_enable ? inc(rx_wp_q) : '0;
      end
      if (pop_rx) begin
        rx_rp_q <= enhanced_buffer_enable ? inc(rx_rp_q) : '0;
      end
      tx_cnt_q <= tx_cnt_q + CNT_W'(push_tx) - CNT_W'(start);
      rx_cnt_q <= rx_cnt_q + CNT_W'(push_rx) - CNT_W'(pop_rx);
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt conditions.
  // ---------------------------------------------------------------------------
  wire logic rx_3q = (32'(rx_cnt_q) * 4 >= 32'(limit) * 3);
  wire logic [7:0] cond;
  logic [7:0] cond_q;
  logic       flag_q;
  logic [WORD_W-1:0] rx_data_q;

  assign cond[smb_pkg::ISEL_RX_EMPTY]    = (rx_cnt_q == '0);
  assign cond[smb_pkg::ISEL_RX_NONEMPTY] = (rx_cnt_q != '0);
  assign cond[smb_pkg::ISEL_RX_3QUARTER] = rx_3q;
  assign cond[smb_pkg::ISEL_RX_FULL]     = rx_full_w;
  assign cond[smb_pkg::ISEL_SR_LOADED]   = busy;
  assign cond[smb_pkg::ISEL_XFER_DONE]   = !busy && tx_empty;
  assign cond[smb_pkg::ISEL_TX_EMPTY]    = tx_empty;
  assign cond[smb_pkg::ISEL_TX_NOTFULL]  = !tx_full_w;

  wire logic [7:0] rise   = cond & ~cond_q;
  wire logic enh_set      = rise[buffer_interrupt_select];
  wire logic flag_set     = enhanced_buffer_enable ? enh_set : done_evt;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cond_q    <= '1;
      flag_q    <= smb_pkg::RST_FLAG;
      rx_data_q <= '0;
    end else begin
      cond_q    <= cond;
      flag_q    <= flag_set || (flag_q && !interrupt_clear);
      rx_data_q <= rx_mem[rx_rp_q];
    end
  end

  // ---------------------------------------------------------------------------
  // Link engine and outputs.
  // ---------------------------------------------------------------------------
  smb_shift_engine #(
    .WORD_W (WORD_W)
  ) u_engine (
    .link_clock  (link_clock),
    .rst         (rst),
    .start_toggle(req_q),
    .tx_word     (hold_q),
    .cfg         ({clock_edge_select, clock_idle_level}),
    .miso        (miso),
    .done_toggle (link_done),
    .rx_word     (link_rx),
    .sck         (sck),
    .mosi        (mosi)
  );

  assign rx_data                   = rx_data_q;
  assign tx_full                   = tx_full_w;
  assign receive_buffer_full_flag  = (rx_cnt_q != '0);
  assign shift_register_empty_flag = !busy;
  assign serial_interrupt_flag     = flag_q;
  assign serial_status_register    = '{
    shift_register_empty_flag: !busy,
    reserved:                  2'h0,
    buffer_interrupt_select:   buffer_interrupt_select,
    tx_full:                   tx_full_w,
    receive_buffer_full_flag:  (rx_cnt_q != '0)};

  xfer_done_a: assert property (@(posedge clock) disable iff (rst)
    enhanced_buffer_enable &&
    buffer_interrupt_select == smb_pkg::ISEL_XFER_DONE &&
    $rose(flag_q) |-> !busy)
    else $error("transfer complete interrupt while shifter busy");

  tx_empty_a: assert property (@(posedge clock) disable iff (rst)
    enhanced_buffer_enable &&
    buffer_interrupt_select == smb_pkg::ISEL_TX_EMPTY &&
    $stable(buffer_interrupt_select) && tx_empty && !$past(tx_empty)
    |=> flag_q)
    else $error("no interrupt when transmit buffer emptied");

  shift_register_empty_flag_busy_a: assert property (@(posedge clock) disable iff (rst)
    start |=> !shift_register_empty_flag && serial_status_register[7] == 1'b0)
    else $error("shift register empty shown during transfer");

  rbf_cause_a: assert property (@(posedge clock) disable iff (rst)
    $rose(receive_buffer_full_flag) |-> $past(done_evt))
    else $error("receive full raised without completed word");

  std_flag_a: assert property (@(posedge clock) disable iff (rst)
    !enhanced_buffer_enable && $rose(flag_q) |-> $past(done_evt))
    else $error("standard mode interrupt raised early");

  hold_word_a: assert property (@(posedge clock) disable iff (rst)
    busy && !start |=> $stable(hold_q))
    else $error("word in shifter disturbed by a write");

  std_depth_a: assert property (@(posedge clock) disable iff (rst)
    !enhanced_buffer_enable && $stable(enhanced_buffer_enable)
    |-> tx_cnt_q <= CNT_W'(1) || $past(enhanced_buffer_enable))
    else $error("standard mode holds more than one word");

endmodule

/* File: verification/smb_slave_model.sv */
// -----------------------------------------------------------------------------
// Serial slave that echoes each received word back in the next frame.
// -----------------------------------------------------------------------------
module smb_slave_model #(
  parameter logic [7:0] REPLY0 = 8'h5A
) (
  input  wire logic       rst,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       cke,
  input  wire logic       idle,
  output logic            miso,
  output logic [7:0]      got,
  output int              n_got
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_in;
  logic [7:0] sh_out;
  int         nbit;
  // Samples on one clock edge and changes its output on the other; with cke set, the next word's first bit is driven on the last sample edge.
  always @(sck or posedge rst) begin
    if (rst) begin
      sh_in  <= 8'h00;
      sh_out <= REPLY0;
      miso   <= REPLY0[7];
      nbit   <= 0;
      n_got  <= 0;
      got    <= 8'h00;
    end else if ((sck != idle) == cke) begin
      sh_in <= {sh_in[6:0], mosi};
      nbit  <= (nbit == 7) ? 0 : nbit + 1;
      if (nbit == 7) begin
        got    <= {sh_in[6:0], mosi};
        sh_out <= {sh_in[6:0], mosi};
        n_got  <= n_got + 1;
        if (cke) begin
          miso <= sh_in[6];
        end
      end
    end else if (!cke || nbit != 0) begin
      miso <= sh_out[7-nbit];
    end
  end
endmodule

/* File: verification/smb_spi_master_tb.sv */
module smb_spi_master_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic       cke;
    logic       idle;
    logic [7:0] a;
    logic [7:0] b;
  } smb_row_type;
  localparam logic [7:0] REPLY0 = 8'h5A;
  smb_row_type             rows [4] = '{'{1'b0, 1'b0, 8'hA5, 8'h3C},
    '{1'b1, 1'b0, 8'h81, 8'h7E}, '{1'b0, 1'b1, 8'hF0, 8'h0F},
    '{1'b1, 1'b1, 8'h96, 8'h69}};
  logic                    clock = 0, link_clock = 0, rst = 1, slv_rst = 1;
  logic                    enhanced_buffer_enable = 0;
  logic [2:0]              buffer_interrupt_select = 3'h0;
  logic                    clock_edge_select = 0, clock_idle_level = 0;
  logic [7:0]              tx_data = 8'h00;
  logic                    tx_write = 0, rx_read = 0, interrupt_clear = 0;
  logic [7:0]              rx_data, got;
  logic                    tx_full, receive_buffer_full_flag;
  logic                    shift_register_empty_flag, serial_interrupt_flag;
  smb_pkg::smb_status_type serial_status_register;
  logic                    sck, mosi, miso;
  int                      n_got, n_mismatch = 0, check_count = 0;
  always #5 clock = ~clock;
  always #6 link_clock = ~link_clock;
  smb_spi_master uut (.clock(clock), .rst(rst), .link_clock(link_clock),
    .enhanced_buffer_enable(enhanced_buffer_enable),
    .buffer_interrupt_select(buffer_interrupt_select),
    .clock_edge_select(clock_edge_select),
    .clock_idle_level(clock_idle_level), .tx_data(tx_data),
    .tx_write(tx_write), .rx_read(rx_read),
    .interrupt_clear(interrupt_clear), .rx_data(rx_data), .tx_full(tx_full),
    .receive_buffer_full_flag(receive_buffer_full_flag),
    .shift_register_empty_flag(shift_register_empty_flag),
    .serial_interrupt_flag(serial_interrupt_flag),
    .serial_status_register(serial_status_register), .sck(sck),
    .mosi(mosi), .miso(miso));
  smb_slave_model #(.REPLY0(REPLY0)) slave (.rst(slv_rst), .sck(sck),
    .mosi(mosi), .cke(clock_edge_select), .idle(clock_idle_level),
    .miso(miso), .got(got), .n_got(n_got));
  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic put(input logic [7:0] w);
    @(posedge clock);
    tx_data  <= w;
    tx_write <= 1'b1;
    @(posedge clock);
    tx_write <= 1'b0;
  endtask
  task automatic pop;
    @(posedge clock);
    rx_read         <= 1'b1;
    interrupt_clear <= 1'b1;
    @(posedge clock);
    rx_read         <= 1'b0;
    interrupt_clear <= 1'b0;
  endtask
  task automatic wait_rbf;
    for (int i = 0; i < 400; i++) begin
      @(posedge clock);
      #1;
      if (receive_buffer_full_flag === 1'b1) begin
        return;
      end
    end
    chk8("wait", 8'h01, 8'h00);
    final_report;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic burst(input logic [2:0] sel);
    int i;
    @(posedge clock);
    enhanced_buffer_enable  <= 1'b1;
    buffer_interrupt_select <= sel;
    slv_rst                 <= 1'b1;
    @(posedge clock);
    slv_rst <= 1'b0;
    put(8'hC3);
    put(8'h3C);
    put(8'h81);
    for (i = 0; i < 600; i++) begin
      @(posedge clock);
      #1;
      if (serial_interrupt_flag === 1'b1) begin
        break;
      end
    end
    chk8("int raised", 8'h01, {7'h0, i < 600});
    if (i == 600) begin
      final_report;
    end
    chk8("status", {sel == smb_pkg::ISEL_XFER_DONE, 2'b00, sel, 1'b0,
      sel == smb_pkg::ISEL_XFER_DONE}, serial_status_register);
    if (sel == smb_pkg::ISEL_XFER_DONE) begin
      chk8("empty at int", 8'h01, {7'h0, shift_register_empty_flag});
      chk8("words at int", 8'h03, n_got[7:0]);
    end else begin
      chk8("early int", 8'h01, {7'h0, n_got < 3});
    end
    repeat (120) @(posedge clock);
    #1;
    chk8("rx a", REPLY0, rx_data);
    pop();
    @(posedge clock);
    #1;
    chk8("rx b", 8'hC3, rx_data);
    pop();
    @(posedge clock);
    #1;
    chk8("rx c", 8'h3C, rx_data);
    pop();
    $display("enhanced test %0d done", sel);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk8("reset status", 8'h80, serial_status_register);
    chk8("reset sck", 8'h00, {7'h0, sck});
    chk8("reset int", 8'h00, {7'h0, serial_interrupt_flag});
    $display("reset test done");
    foreach (rows[k]) begin
      @(posedge clock);
      clock_edge_select <= rows[k].cke;
      clock_idle_level  <= rows[k].idle;
      slv_rst           <= 1'b1;
      repeat (6) @(posedge clock);
      slv_rst <= 1'b0;
      put(rows[k].a);
      put(rows[k].b);
      #1;
      chk8("tx full", 8'h01, {7'h0, tx_full});
      wait_rbf;
      chk8("int with rbf", 8'h01, {7'h0, serial_interrupt_flag});
      @(posedge clock);
      #1;
      chk8("rx first", REPLY0, rx_data);
      chk8("slave first", rows[k].a, got);
      pop();
      wait_rbf;
      chk8("int second", 8'h01, {7'h0, serial_interrupt_flag});
      @(posedge clock);
      #1;
      chk8("rx second", rows[k].a, rx_data);
      chk8("slave second", rows[k].b, got);
      chk8("slave count", 8'h02, n_got[7:0]);
      chk8("sck idle", {7'h0, rows[k].idle}, {7'h0, sck});
      pop();
      $display("row %0d done", k);
    end
    burst(smb_pkg::ISEL_XFER_DONE);
    burst(smb_pkg::ISEL_TX_EMPTY);
    final_report;
  end
endmodule
